// ==== hw/adc_trig_pkg.sv ====
package adc_trig_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CHAN_RUN  = 8'h00;
  localparam logic [7:0] ADDR_FORMAT    = 8'h04;
  localparam logic [7:0] ADDR_TRIG_SEL  = 8'h08;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'h0C;
  localparam logic [7:0] ADDR_RES_LOW   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h1C;
  localparam logic [7:0] ADDR_CONV_DATA = 8'h20;
  // Field positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_GO       = 1;
  localparam int BIT_JUSTIFY  = 7;
  localparam int TRIG_LSB     = 4;
  localparam logic [7:0] CHAN_RUN_MASK = 8'h7F;
  localparam logic [7:0] FORMAT_MASK   = 8'hF3;
  localparam logic [7:0] TRIG_MASK     = 8'hF0;
  // Interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_TMR0  = 1;
  localparam int IRQ_TMR1  = 2;
  localparam int IRQ_BITS  = 3;
  // Trigger codes
  localparam logic [3:0] TRIG_NONE = 4'h0;
  localparam logic [3:0] TRIG_CCP1 = 4'h1;
  localparam logic [3:0] TRIG_CCP2 = 4'h2;
  localparam logic [3:0] TRIG_T0   = 4'h3;
  localparam logic [3:0] TRIG_T1   = 4'h4;
  localparam logic [3:0] TRIG_T2   = 4'h5;
  localparam logic [3:0] TRIG_C1   = 4'h6;
  localparam logic [3:0] TRIG_C2   = 4'h7;
  localparam logic [3:0] TRIG_M1W  = 4'h8;
  localparam logic [3:0] TRIG_M1P  = 4'h9;
  localparam logic [3:0] TRIG_M2W  = 4'hA;
  localparam logic [3:0] TRIG_M2P  = 4'hB;
  localparam logic [3:0] TRIG_T4   = 4'hC;
  localparam logic [3:0] TRIG_T6   = 4'hD;
  localparam logic [3:0] TRIG_M1M  = 4'hE;
  localparam logic [3:0] TRIG_M2M  = 4'hF;
  localparam int NUM_SRC = 15;
  localparam int RES_W   = 10;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== hw/adc_trigger_and_result_format.sv ====
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module adc_trigger_and_result_format
  import adc_trig_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [NUM_SRC-1:0]   trig_src,
  input  wire logic                 conv_done,
  input  wire logic [RES_W-1:0]     conv_result,
  output logic                      conv_start_reg,
  output logic                      converter_enable_reg,
  output logic [4:0]                input_channel_select_reg,
  output logic                      irq_reg
);

  // Trigger sources arrive as pins of other blocks; bit n is code n+1
  logic [NUM_SRC-1:0] src_meta_reg, src_sync_reg, src_prev_reg;
  logic [7:0] chan_run_reg, format_reg, trig_ctrl_reg;
  logic [7:0] result_high_byte_reg, result_low_byte_reg;
  logic [IRQ_BITS-1:0] irq_stat_reg, irq_en_reg;
  logic done_meta_reg, done_sync_reg, done_prev_reg;
  logic [RES_W-1:0] res_meta_reg, res_sync_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  // Selected source level, zero code selects nothing
  function automatic logic pick_src(input logic [3:0] code, input logic [NUM_SRC-1:0] v);
    if (code == TRIG_NONE)
      return 1'b0;
    return v[code - 4'h1];
  endfunction

  // Two-stage synchronisers before anything reads the inputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_meta_reg  <= '0;
      src_sync_reg  <= '0;
      src_prev_reg  <= '0;
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
      done_prev_reg <= 1'b0;
      res_meta_reg  <= '0;
      res_sync_reg  <= '0;
    end else begin
      src_meta_reg  <= trig_src;
      src_sync_reg  <= src_meta_reg;
      src_prev_reg  <= src_sync_reg;
      done_meta_reg <= conv_done;
      done_sync_reg <= done_meta_reg;
      done_prev_reg <= done_sync_reg;
      res_meta_reg  <= conv_result;
      res_sync_reg  <= res_meta_reg;
    end
  end

  // Edge of the selected source; comparing same-code samples avoids
  // a false edge when software changes the selection
  logic trig_edge;
  logic done_edge;
  logic busy;
  assign trig_edge = pick_src(trig_ctrl_reg[7:4], src_sync_reg) &
                     ~pick_src(trig_ctrl_reg[7:4], src_prev_reg);
  assign done_edge = done_sync_reg & ~done_prev_reg;
  assign busy      = chan_run_reg[BIT_GO];

  // Write channel: capture address and data in either order
  logic wr_fire;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg <= ADDR_IRQ_CLR && aw_addr_reg[1:0] == 2'b00)
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_lane0;
  assign wr_lane0 = wr_fire && w_strb_reg[0];

  // Control registers; hardware start and clear of the go flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_run_reg   <= RESET_BYTE;
      format_reg     <= RESET_BYTE;
      trig_ctrl_reg  <= RESET_BYTE;
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= 1'b0;
      if (wr_lane0 && aw_addr_reg == ADDR_FORMAT)
        format_reg <= w_data_reg[7:0] & FORMAT_MASK;
      if (wr_lane0 && aw_addr_reg == ADDR_TRIG_SEL)
        trig_ctrl_reg <= w_data_reg[7:0] & TRIG_MASK;
      if (wr_lane0 && aw_addr_reg == ADDR_CHAN_RUN) begin
        chan_run_reg[7:2]        <= w_data_reg[7:2] & CHAN_RUN_MASK[7:2];
        chan_run_reg[BIT_ENABLE] <= w_data_reg[BIT_ENABLE];
        // Software may start but not abort a running conversion
        if (w_data_reg[BIT_GO] && !busy && w_data_reg[BIT_ENABLE]) begin
          chan_run_reg[BIT_GO] <= 1'b1;
          conv_start_reg       <= 1'b1;
        end
      end
      if (busy && done_edge) begin
        chan_run_reg[BIT_GO] <= 1'b0;
      end else if (trig_edge && !busy && chan_run_reg[BIT_ENABLE]) begin
        chan_run_reg[BIT_GO] <= 1'b1;
        conv_start_reg       <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      converter_enable_reg     <= 1'b0;
      input_channel_select_reg <= '0;
    end else begin
      converter_enable_reg     <= chan_run_reg[BIT_ENABLE];
      input_channel_select_reg <= chan_run_reg[6:2];
    end
  end

  // Result load: both bytes in one cycle, unused bits zeroed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_high_byte_reg <= RESET_BYTE;
      result_low_byte_reg  <= RESET_BYTE;
    end else if (busy && done_edge) begin
      if (format_reg[BIT_JUSTIFY]) begin
        result_high_byte_reg <= {6'b00_0000, res_sync_reg[9:8]};
        result_low_byte_reg  <= res_sync_reg[7:0];
      end else begin
        result_high_byte_reg <= res_sync_reg[9:2];
        result_low_byte_reg  <= {res_sync_reg[1:0], 6'b00_0000};
      end
    end else if (wr_lane0 && aw_addr_reg == ADDR_RES_HIGH) begin
      result_high_byte_reg <= w_data_reg[7:0];
    end else if (wr_lane0 && aw_addr_reg == ADDR_RES_LOW) begin
      result_low_byte_reg <= w_data_reg[7:0];
    end
  end

  // Interrupt flags; a new event wins over a clear in the same cycle
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;
  assign irq_set = {src_sync_reg[TRIG_T1 - 4'h1] & ~src_prev_reg[TRIG_T1 - 4'h1],
                    src_sync_reg[TRIG_T0 - 4'h1] & ~src_prev_reg[TRIG_T0 - 4'h1],
                    busy & done_edge};
  assign irq_clr = (wr_lane0 && aw_addr_reg == ADDR_IRQ_CLR) ? w_data_reg[IRQ_BITS-1:0] : '0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_lane0 && aw_addr_reg == ADDR_IRQ_EN)
        irq_en_reg <= w_data_reg[IRQ_BITS-1:0];
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Read channel, one cycle after the address is taken
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_CHAN_RUN:  s_axi_rdata <= {24'h00_0000, chan_run_reg};
          ADDR_FORMAT:    s_axi_rdata <= {24'h00_0000, format_reg};
          ADDR_TRIG_SEL:  s_axi_rdata <= {24'h00_0000, trig_ctrl_reg};
          ADDR_RES_HIGH:  s_axi_rdata <= {24'h00_0000, result_high_byte_reg};
          ADDR_RES_LOW:   s_axi_rdata <= {24'h00_0000, result_low_byte_reg};
          ADDR_IRQ_STAT:  s_axi_rdata <= {29'h0000_0000, irq_stat_reg};
          ADDR_IRQ_EN:    s_axi_rdata <= {29'h0000_0000, irq_en_reg};
          ADDR_IRQ_CLR:   s_axi_rdata <= '0;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_no_trig_when_zero;
    trig_ctrl_reg[7:4] == TRIG_NONE && !(wr_lane0 && aw_addr_reg == ADDR_CHAN_RUN)
      |=> !conv_start_reg;
  endproperty
  a_no_trig_when_zero: assert property (p_no_trig_when_zero)
    else $error("start with no source");

  property p_edge_starts;
    trig_edge && !busy && chan_run_reg[BIT_ENABLE] && !done_edge |=> busy && conv_start_reg;
  endproperty
  a_edge_starts: assert property (p_edge_starts)
    else $error("edge did not start");

  // A level already high on the previous sample must never start anything unless software writes the go bit
  property p_level_no_restart;
    pick_src(trig_ctrl_reg[7:4], src_sync_reg) && pick_src(trig_ctrl_reg[7:4], src_prev_reg)
      && !(wr_lane0 && aw_addr_reg == ADDR_CHAN_RUN)
      |=> !conv_start_reg;
  endproperty
  a_level_no_restart: assert property (p_level_no_restart)
    else $error("level restarted");

  property p_tmr0_flag;
    src_sync_reg[TRIG_T0 - 4'h1] && !src_prev_reg[TRIG_T0 - 4'h1] |=> irq_stat_reg[IRQ_TMR0];
  endproperty
  a_tmr0_flag: assert property (p_tmr0_flag)
    else $error("timer flag lost");

  property p_tmr1_flag;
    src_sync_reg[TRIG_T1 - 4'h1] && !src_prev_reg[TRIG_T1 - 4'h1] |=> irq_stat_reg[IRQ_TMR1];
  endproperty
  a_tmr1_flag: assert property (p_tmr1_flag)
    else $error("timer flag lost");

  property p_left_load;
    busy && done_edge && !format_reg[BIT_JUSTIFY]
      |=> result_high_byte_reg == $past(res_sync_reg[9:2])
          && result_low_byte_reg == {$past(res_sync_reg[1:0]), 6'b00_0000};
  endproperty
  a_left_load: assert property (p_left_load)
    else $error("left load wrong");

  property p_right_load;
    busy && done_edge && format_reg[BIT_JUSTIFY]
      |=> result_high_byte_reg == {6'b00_0000, $past(res_sync_reg[9:8])}
          && result_low_byte_reg == $past(res_sync_reg[7:0]);
  endproperty
  a_right_load: assert property (p_right_load)
    else $error("right load wrong");

  property p_done_clears;
    busy && done_edge |=> !busy;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("go not cleared");

  property p_busy_ignores;
    busy && !done_edge |=> !conv_start_reg;
  endproperty
  a_busy_ignores: assert property (p_busy_ignores)
    else $error("restart while busy");

  // Start is one cycle wide; the converter counts each pulse that arrives while it is idle as a conversion
  property p_start_pulse;
    conv_start_reg |=> !conv_start_reg;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");

  // Interrupt output follows the enabled status one cycle later
  property p_irq_high;
    (|(irq_stat_reg & irq_en_reg)) |=> irq_reg;
  endproperty
  a_irq_high: assert property (p_irq_high)
    else $error("interrupt missing");

  property p_irq_low;
    !(|(irq_stat_reg & irq_en_reg)) |=> !irq_reg;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt without cause");

  // A taken response is gone on the next edge, so no beat is seen twice
  property p_bresp_taken;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bresp_taken: assert property (p_bresp_taken)
    else $error("write response repeated");

  property p_rresp_taken;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rresp_taken: assert property (p_rresp_taken)
    else $error("read response repeated");

  c_auto_conv: cover property (trig_edge && !busy ##[1:50] done_edge);
  c_right: cover property (busy && done_edge && format_reg[BIT_JUSTIFY]);
  c_left: cover property (busy && done_edge && !format_reg[BIT_JUSTIFY]);
  c_level_held: cover property (pick_src(trig_ctrl_reg[7:4], src_sync_reg)
                                && pick_src(trig_ctrl_reg[7:4], src_prev_reg) && !busy);
  c_irq: cover property (irq_reg);

endmodule

// ==== sim/conv_model.sv ====
`timescale 1ns/1ps
// Behavioural converter answering each start received while idle after a set latency
module conv_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       conv_start_reg,
  input  wire logic [9:0] result_value,
  input  wire logic [7:0] latency,
  output logic            conv_done,
  output logic [9:0]      conv_result
);
  logic [7:0] cnt_reg;
  logic       busy_reg;

  // Result valid one cycle ahead of done; inverted once done drops,
  // so a late sample of stale data can never read right
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg    <= 1'b0;
      cnt_reg     <= 8'h00;
      conv_done   <= 1'b0;
      conv_result <= 10'h000;
    end else if (conv_start_reg && !busy_reg) begin
      busy_reg <= 1'b1;
      cnt_reg  <= latency + 8'h0A;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
      if (cnt_reg == 8'h0A) conv_result <= result_value;
      if (cnt_reg == 8'h09) conv_done <= 1'b1;
      if (cnt_reg == 8'h01) begin
        conv_done   <= 1'b0;
        conv_result <= ~result_value;
        busy_reg    <= 1'b0;
      end
    end
  end
endmodule

// ==== sim/adc_trigger_and_result_format_bench.sv ====
`timescale 1ns/1ps
module adc_trigger_and_result_format_bench
  import adc_trig_pkg::*;
;
  localparam int ACQ_CYCLES = 874;
  logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, conv_done, conv_start_reg, en_o, irq_o;
  logic [7:0]  awaddr, araddr, rd_data;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic [14:0] trig;
  logic [9:0]  res_val, conv_result;
  logic [4:0]  chan_o;
  int          err_count, samples_checked, starts, c;

  adc_trigger_and_result_format i_adc_trigger_and_result_format (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_src(trig),
    .conv_done(conv_done), .conv_result(conv_result),
    .conv_start_reg(conv_start_reg), .converter_enable_reg(en_o),
    .input_channel_select_reg(chan_o), .irq_reg(irq_o));

  conv_model i_conv_model (
    .clk(clk), .sys_rst(sys_rst), .conv_start_reg(conv_start_reg),
    .result_value(res_val), .latency(8'h1E), .conv_done(conv_done),
    .conv_result(conv_result));

  // Clock and start counter
  always #2.5 clk = ~clk;
  always @(posedge clk) if (conv_start_reg) starts <= starts + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A wait that ran out of its bound ends the run as a failure
  task automatic tmo(input bit expired);
    if (expired) begin
      err_count++;
      tally_and_finish();
    end
  endtask

  // Bus write; each channel released on its own handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    bit ap;
    bit wp;
    bit bp;
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 200 && (ap || wp || bp); n++) begin
      @(posedge clk);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
      if (bp && bvalid) begin
        bp = 1'b0;
        bready <= 1'b0;
        wr_resp = bresp;
      end
    end
    tmo(ap || wp || bp);
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    bit ap;
    bit rp;
    ap = 1'b1;
    rp = 1'b1;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 200 && (ap || rp); n++) begin
      @(posedge clk);
      if (ap && arready) begin
        ap = 1'b0;
        arvalid <= 1'b0;
      end
      if (rp && rvalid) begin
        rp = 1'b0;
        rready <= 1'b0;
        rd_data = rdata[7:0];
        rd_resp = rresp;
      end
    end
    tmo(ap || rp);
    @(posedge clk);
  endtask

  // Polling the go flag, as software would
  task automatic wait_idle;
    int n;
    for (n = 0; n < 200; n++) begin
      rd(ADDR_CHAN_RUN);
      if (rd_data[BIT_GO] === 1'b0) break;
    end
    tmo(n >= 200);
  endtask

  task automatic wait_starts(input int e);
    int n;
    for (n = 0; n < 200; n++) begin
      if (starts == e) break;
      @(posedge clk);
    end
    tmo(n >= 200);
  endtask

  function automatic logic [7:0] ehi(input logic [9:0] r, input logic j);
    return j ? {6'h00, r[9:8]} : r[9:2];
  endfunction
  function automatic logic [7:0] elo(input logic [9:0] r, input logic j);
    return j ? r[7:0] : {r[1:0], 6'h00};
  endfunction

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    trig = 15'h0000;
    res_val = 10'h000;
    starts = 0;
    err_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // Reset value and refused addresses
    rd(ADDR_TRIG_SEL);
    chk(rd_data, RESET_BYTE);
    rd(8'h24);
    chk({6'h00, rd_resp}, {6'h00, RESP_SLVERR});
    chk(rd_data, 8'h00);
    wr(8'h24, 8'h55);
    chk({6'h00, wr_resp}, {6'h00, RESP_SLVERR});
    // Channel 3, enabled, then the settling wait before any start
    wr(ADDR_CHAN_RUN, 8'h0D);
    repeat (ACQ_CYCLES) @(posedge clk);
    chk({7'h00, en_o}, 8'h01);
    chk({3'h0, chan_o}, 8'h03);
    res_val <= 10'h3FF;
    wr(ADDR_FORMAT, 8'h80);
    wr(ADDR_CHAN_RUN, 8'h0F);
    wait_starts(1);
    wait_idle();
    rd(ADDR_RES_HIGH);
    chk(rd_data, 8'h03);
    rd(ADDR_RES_LOW);
    chk(rd_data, 8'hFF);
    // Code zero: every source rising must start nothing
    wr(ADDR_TRIG_SEL, 8'h00);
    trig <= 15'h7FFF;
    repeat (12) @(posedge clk);
    chk(starts[7:0], 8'h01);
    trig <= 15'h0000;
    repeat (4) @(posedge clk);
    // Clear all flags, so only conversion ends and T0 or T1 edges, selected or not, can set them again
    wr(ADDR_IRQ_CLR, 8'h07);
    rd(ADDR_IRQ_STAT);
    chk(rd_data, 8'h00);
    // Every nonzero code, alternating justification; second rise lands mid-conversion
    for (c = 1; c < 16; c++) begin
      res_val <= 10'h2A5 ^ c[9:0];
      wr(ADDR_FORMAT, {c[0], 7'h00});
      wr(ADDR_TRIG_SEL, {c[3:0], 4'h0});
      trig <= 15'h0001 << (c - 1);
      wait_starts(c + 1);
      chk(starts[7:0], 8'(c + 1));
      rd(ADDR_CHAN_RUN);
      chk({7'h00, rd_data[BIT_GO]}, 8'h01);
      trig <= 15'h0000;
      repeat (4) @(posedge clk);
      trig <= 15'h0001 << (c - 1);
      wait_idle();
      chk(starts[7:0], 8'(c + 1));
      repeat (8) @(posedge clk);
      chk(starts[7:0], 8'(c + 1));
      trig <= 15'h0000;
      rd(ADDR_RES_HIGH);
      chk(rd_data, ehi(res_val, c[0]));
      rd(ADDR_RES_LOW);
      chk(rd_data, elo(res_val, c[0]));
    end
    // Interrupt: sticky flags, mask, clear
    rd(ADDR_IRQ_STAT);
    chk(rd_data, 8'h07);
    chk({7'h00, irq_o}, 8'h00);
    wr(ADDR_IRQ_EN, 8'h06);
    repeat (2) @(posedge clk);
    chk({7'h00, irq_o}, 8'h01);
    wr(ADDR_IRQ_CLR, 8'h06);
    repeat (2) @(posedge clk);
    chk({7'h00, irq_o}, 8'h00);
    rd(ADDR_IRQ_STAT);
    chk(rd_data, 8'h01);
    // Result bytes stay writable by software while idle
    wr(ADDR_RES_LOW, 8'h5A);
    rd(ADDR_RES_LOW);
    chk(rd_data, 8'h5A);
    // With the converter disabled a software go starts nothing
    wr(ADDR_CHAN_RUN, 8'h0E);
    repeat (8) @(posedge clk);
    chk(starts[7:0], 8'h10);
    rd(ADDR_CHAN_RUN);
    chk(rd_data, 8'h0C);
    tally_and_finish();
  end
endmodule
